// file: src/accr_regs.svh
`ifndef ACCR_REGS_SVH
`define ACCR_REGS_SVH

// Register offsets on the 8-bit configuration port
`define ACCR_OFS_REF_CFG_ADDR   8'h65
`define ACCR_AVG_ADDR           8'h68
`define ACCR_STATE_ADDR         8'h6a
`define ACCR_PIN_SETUP_ADDR     8'h6b
`define ACCR_SOFT_TRIG_ADDR     8'h6c
`define ACCR_IRQ_STATUS_ADDR    8'h90
`define ACCR_IRQ_MASK_ADDR      8'h91
`define ACCR_CONTROL_ADDR       8'h92

// Reset values
`define ACCR_OFS_REF_CFG_RST    8'h01
`define ACCR_AVG_RST            8'h61
`define ACCR_PIN_SETUP_RST      8'h00
`define ACCR_SOFT_TRIG_RST      8'h01
`define ACCR_IRQ_MASK_RST       3'h0
`define ACCR_CONTROL_RST        8'h05

// Field positions
`define ACCR_OFS_REF_SEL_BIT    2
`define ACCR_OFS_AVG_MSB        6
`define ACCR_OFS_AVG_LSB        4
`define ACCR_LIN_AVG_MSB        2
`define ACCR_LIN_AVG_LSB        0
`define ACCR_STAT_SEL_MSB       2
`define ACCR_STAT_SEL_LSB       1
`define ACCR_TRIG_SRC_BIT       0
`define ACCR_SOFT_TRIG_BIT      0
`define ACCR_CTRL_RUN_BIT       0
`define ACCR_CTRL_BG_BIT        1
`define ACCR_CTRL_FG_BIT        2

// Interrupt status bits
`define ACCR_IRQ_FG_BIT         0
`define ACCR_IRQ_HALT_BIT       1
`define ACCR_IRQ_ALARM_BIT      2

// Status output select codes
`define ACCR_SEL_FOREGROUND_COMPLETE_FLAG        2'h0
`define ACCR_SEL_HALTED         2'h1
`define ACCR_SEL_ALARM          2'h2

// Converter mid-code used as the zero-offset reference
`define ACCR_MID_CODE           12'h800

// Base calibration phase length in cycles, doubled per averaging code
`define ACCR_PHASE_BASE         12'h010

`endif

// file: src/accr_pkg.sv
package accr_pkg;

    typedef enum logic [4:0] {
        ACCR_ST_IDLE    = 5'h01,
        ACCR_ST_FG_RUN  = 5'h02,
        ACCR_ST_FG_END  = 5'h04,
        ACCR_ST_BG_RUN  = 5'h08,
        ACCR_ST_BG_HALT = 5'h10
    } accr_eng_state_t;

    typedef struct packed {
        accr_eng_state_t state;
        logic [11:0]     cnt;
        logic            foreground_complete_flag;
        logic            halted;
        logic [2:0]      code;
    } accr_eng_t;

    typedef struct packed {
        logic [7:0]  ofs_ref_cfg;
        logic [7:0]  avg_cfg;
        logic [7:0]  pin_setup;
        logic [7:0]  soft_trig;
        logic [7:0]  control;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [1:0]  trig_sync;
        logic [1:0]  alarm_sync;
        logic [2:0]  evt_prev;
        logic [7:0]  rd_data;
        logic        status_pin;
        logic        irq;
        logic        cal_trigger;
        logic [12:0] ofs_err;
    } accr_top_t;

endpackage

// file: src/accr_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "accr_regs.svh"

module accr_engine (
    input  wire logic       clk_i,        // Register clock
    input  wire logic       rst_n_i,      // Synchronous reset, active low
    input  wire logic       run_en_i,     // Calibration run enable
    input  wire logic       fg_en_i,      // Foreground calibration enable
    input  wire logic       bg_en_i,      // Background calibration enable
    input  wire logic       trig_i,       // Selected calibration trigger
    input  wire logic [2:0] lin_avg_i,    // Linearity averaging depth
    input  wire logic [2:0] ofs_avg_i,    // Offset averaging depth
    output logic            foreground_complete_flag_o,    // Foreground complete or skipped
    output logic            halted_o,     // Background halted
    output logic [2:0]      code_o        // Engine state code
);

    accr_pkg::accr_eng_t s_r;
    accr_pkg::accr_eng_t s_nxt;

    // Phase length grows with the averaging depth
    function automatic logic [11:0] phase_last(input logic [2:0] depth);
        phase_last = (`ACCR_PHASE_BASE << depth) - 12'h001;
    endfunction

    function automatic logic [2:0] state_code(input accr_pkg::accr_eng_state_t st);
        unique case (st)
            accr_pkg::ACCR_ST_IDLE:    state_code = 3'h0;
            accr_pkg::ACCR_ST_FG_RUN:  state_code = 3'h1;
            accr_pkg::ACCR_ST_FG_END:  state_code = 3'h2;
            accr_pkg::ACCR_ST_BG_RUN:  state_code = 3'h3;
            accr_pkg::ACCR_ST_BG_HALT: state_code = 3'h4;
            default:                   state_code = 3'h7;
        endcase
    endfunction

    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = s_r.cnt + 12'h001;
        unique case (s_r.state)
            accr_pkg::ACCR_ST_IDLE: begin
                s_nxt.cnt = 12'h000;
                if (fg_en_i) begin
                    s_nxt.state = accr_pkg::ACCR_ST_FG_RUN;
                end else begin
                    s_nxt.state = accr_pkg::ACCR_ST_FG_END;
                end
            end
            accr_pkg::ACCR_ST_FG_RUN: begin
                if (s_r.cnt == phase_last(lin_avg_i)) begin
                    s_nxt.state = accr_pkg::ACCR_ST_FG_END;
                end
            end
            accr_pkg::ACCR_ST_FG_END: begin
                s_nxt.cnt = 12'h000;
                s_nxt.foreground_complete_flag = 1'b1;
                s_nxt.halted = !bg_en_i;
                if (bg_en_i) begin
                    s_nxt.state = accr_pkg::ACCR_ST_BG_RUN;
                end
            end
            accr_pkg::ACCR_ST_BG_RUN: begin
                s_nxt.halted = 1'b0;
                if (!bg_en_i) begin
                    s_nxt.state = accr_pkg::ACCR_ST_FG_END;
                end else if (s_r.cnt == phase_last(ofs_avg_i)) begin
                    s_nxt.cnt = 12'h000;
                    // A low trigger stops the engine only at a phase boundary
                    if (!trig_i) begin
                        s_nxt.state = accr_pkg::ACCR_ST_BG_HALT;
                    end
                end
            end
            accr_pkg::ACCR_ST_BG_HALT: begin
                s_nxt.cnt = 12'h000;
                s_nxt.halted = 1'b1;
                if (!bg_en_i) begin
                    s_nxt.state = accr_pkg::ACCR_ST_FG_END;
                end else if (trig_i) begin
                    s_nxt.state = accr_pkg::ACCR_ST_BG_RUN;
                end
            end
            default: begin
                s_nxt.state = accr_pkg::ACCR_ST_IDLE;
            end
        endcase
        // Clearing run enable holds everything in reset
        if (!run_en_i) begin
            s_nxt.state = accr_pkg::ACCR_ST_IDLE;
            s_nxt.cnt = 12'h000;
            s_nxt.foreground_complete_flag = 1'b0;
            s_nxt.halted = 1'b0;
        end
        s_nxt.code = state_code(s_nxt.state);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_r.state <= accr_pkg::ACCR_ST_IDLE;
            s_r.cnt <= 12'h000;
            s_r.foreground_complete_flag <= 1'b0;
            s_r.halted <= 1'b0;
            s_r.code <= 3'h0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign foreground_complete_flag_o = s_r.foreground_complete_flag;
    assign halted_o = s_r.halted;
    assign code_o = s_r.code;

endmodule

`default_nettype wire

// file: src/accr_top.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "accr_regs.svh"

module accr_top (
    input  wire logic        REF_CLK_I,               // Register clock, 50 MHz
    input  wire logic        RST_N_I,                 // Synchronous reset, active low
    input  wire logic [7:0]  ADDR_I,                  // Register address
    input  wire logic [7:0]  WR_DATA_I,               // Register write data
    input  wire logic        WR_STB_I,                // Write strobe
    input  wire logic        RD_STB_I,                // Read strobe
    output logic      [7:0]  RD_DATA_O,               // Read data, cycle after strobe
    input  wire logic        TRIGGER_INPUT_PIN_I,     // Hardware calibration trigger
    input  wire logic        ALARM_I,                 // Alarm flag from the device
    input  wire logic [11:0] CORE_SAMPLE_I,           // Primary core sample
    input  wire logic [11:0] SPARE_SAMPLE_I,          // Spare core sample
    output logic             STATUS_OUTPUT_PIN_O,     // Selected calibration status
    output logic             IRQ_O,                   // Level interrupt
    output logic             OFFSET_REFERENCE_SELECT_O, // Offset reference choice
    output logic      [2:0]  OFFSET_AVERAGE_DEPTH_O,  // Offset averaging depth
    output logic      [2:0]  LINEARITY_AVERAGE_DEPTH_O, // Linearity averaging depth
    output logic             BACKGROUND_ENABLE_O,     // Background calibration on
    output logic             CAL_RUN_O,               // Calibration run enable
    output logic             CAL_TRIGGER_O,           // Selected calibration trigger
    output logic      [12:0] OFFSET_ERROR_O           // Signed offset error to reference
);

    accr_pkg::accr_top_t s_r;
    accr_pkg::accr_top_t s_nxt;

    logic       eng_foreground_complete_flag;
    logic       eng_halted;
    logic [2:0] eng_code;

    // Hit test for a register write
    function automatic logic wr_hit(input logic       stb,
                                    input logic [7:0] addr,
                                    input logic [7:0] target);
        wr_hit = stb && (addr == target);
    endfunction

    // Widen an unsigned sample to a signed operand
    function automatic logic [12:0] widen(input logic [11:0] v);
        widen = {1'b0, v};
    endfunction

    accr_engine accr_engine_inst (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RST_N_I),
        .run_en_i  (s_r.control[`ACCR_CTRL_RUN_BIT]),
        .fg_en_i   (s_r.control[`ACCR_CTRL_FG_BIT]),
        .bg_en_i   (s_r.control[`ACCR_CTRL_BG_BIT]),
        .trig_i    (s_r.cal_trigger),
        .lin_avg_i (s_r.avg_cfg[`ACCR_LIN_AVG_MSB:`ACCR_LIN_AVG_LSB]),
        .ofs_avg_i (s_r.avg_cfg[`ACCR_OFS_AVG_MSB:`ACCR_OFS_AVG_LSB]),
        .foreground_complete_flag_o (eng_foreground_complete_flag),
        .halted_o  (eng_halted),
        .code_o    (eng_code)
    );

    always_comb begin
        logic [2:0]  events;
        logic [2:0]  evt_now;
        logic [7:0]  rd_mux;
        logic [11:0] ref_sample;
        logic        alarm_lvl;
        events = 3'h0;
        evt_now = 3'h0;
        rd_mux = 8'h00;
        ref_sample = 12'h000;
        alarm_lvl = 1'b0;

        s_nxt = s_r;

        // Pins from outside the clock domain: two stages before use
        s_nxt.trig_sync = {s_r.trig_sync[0], TRIGGER_INPUT_PIN_I};
        s_nxt.alarm_sync = {s_r.alarm_sync[0], ALARM_I};
        alarm_lvl = s_r.alarm_sync[1];

        // Register writes; reserved bits are stored as written, except in the 3-bit interrupt mask
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_OFS_REF_CFG_ADDR)) begin
            s_nxt.ofs_ref_cfg = WR_DATA_I;
        end
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_AVG_ADDR)) begin
            s_nxt.avg_cfg = WR_DATA_I;
        end
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_PIN_SETUP_ADDR)) begin
            s_nxt.pin_setup = WR_DATA_I;
        end
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_SOFT_TRIG_ADDR)) begin
            s_nxt.soft_trig = WR_DATA_I;
        end
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_CONTROL_ADDR)) begin
            s_nxt.control = WR_DATA_I;
        end
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_IRQ_MASK_ADDR)) begin
            s_nxt.irq_mask = WR_DATA_I[2:0];
        end

        // Trigger source: software bit or synchronised pin
        if (s_r.pin_setup[`ACCR_TRIG_SRC_BIT]) begin
            s_nxt.cal_trigger = s_r.trig_sync[1];
        end else begin
            s_nxt.cal_trigger = s_r.soft_trig[`ACCR_SOFT_TRIG_BIT];
        end

        // Status pin routing
        unique case (s_r.pin_setup[`ACCR_STAT_SEL_MSB:`ACCR_STAT_SEL_LSB])
            `ACCR_SEL_FOREGROUND_COMPLETE_FLAG: s_nxt.status_pin = eng_foreground_complete_flag;
            `ACCR_SEL_HALTED:  s_nxt.status_pin = eng_halted;
            `ACCR_SEL_ALARM:   s_nxt.status_pin = alarm_lvl;
            default:           s_nxt.status_pin = 1'b0;
        endcase

        // Offset reference: mid-code or the spare core's sample.
        // The spare choice is meaningful only with background running.
        if (s_r.ofs_ref_cfg[`ACCR_OFS_REF_SEL_BIT]) begin
            ref_sample = SPARE_SAMPLE_I;
        end else begin
            ref_sample = `ACCR_MID_CODE;
        end
        s_nxt.ofs_err = widen(CORE_SAMPLE_I) - widen(ref_sample);

        // Rising edges of the flags become interrupt events
        evt_now[`ACCR_IRQ_FG_BIT] = eng_foreground_complete_flag;
        evt_now[`ACCR_IRQ_HALT_BIT] = eng_halted;
        evt_now[`ACCR_IRQ_ALARM_BIT] = alarm_lvl;
        events = evt_now & ~s_r.evt_prev;
        s_nxt.evt_prev = evt_now;

        // Write one to clear; a same-cycle event still sets the bit
        if (wr_hit(WR_STB_I, ADDR_I, `ACCR_IRQ_STATUS_ADDR)) begin
            s_nxt.irq_status = (s_r.irq_status & ~WR_DATA_I[2:0]) | events;
        end else begin
            s_nxt.irq_status = s_r.irq_status | events;
        end
        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);

        // Read multiplexer; reading status changes nothing
        unique case (ADDR_I)
            `ACCR_OFS_REF_CFG_ADDR: rd_mux = s_r.ofs_ref_cfg;
            `ACCR_AVG_ADDR:         rd_mux = s_r.avg_cfg;
            `ACCR_STATE_ADDR:       rd_mux = {3'h0, eng_code, eng_halted, eng_foreground_complete_flag};
            `ACCR_PIN_SETUP_ADDR:   rd_mux = s_r.pin_setup;
            `ACCR_SOFT_TRIG_ADDR:   rd_mux = s_r.soft_trig;
            `ACCR_IRQ_STATUS_ADDR:  rd_mux = {5'h00, s_r.irq_status};
            `ACCR_IRQ_MASK_ADDR:    rd_mux = {5'h00, s_r.irq_mask};
            `ACCR_CONTROL_ADDR:     rd_mux = s_r.control;
            default:                rd_mux = 8'h00;
        endcase
        // Read data stands only in the cycle after the strobe
        s_nxt.rd_data = RD_STB_I ? rd_mux : 8'h00;
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            s_r.ofs_ref_cfg <= `ACCR_OFS_REF_CFG_RST;
            s_r.avg_cfg <= `ACCR_AVG_RST;
            s_r.pin_setup <= `ACCR_PIN_SETUP_RST;
            s_r.soft_trig <= `ACCR_SOFT_TRIG_RST;
            s_r.control <= `ACCR_CONTROL_RST;
            s_r.irq_status <= 3'h0;
            s_r.irq_mask <= `ACCR_IRQ_MASK_RST;
            s_r.trig_sync <= 2'h0;
            s_r.alarm_sync <= 2'h0;
            s_r.evt_prev <= 3'h0;
            s_r.rd_data <= 8'h00;
            s_r.status_pin <= 1'b0;
            s_r.irq <= 1'b0;
            s_r.cal_trigger <= 1'b0;
            s_r.ofs_err <= 13'h0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign RD_DATA_O = s_r.rd_data;
    assign STATUS_OUTPUT_PIN_O = s_r.status_pin;
    assign IRQ_O = s_r.irq;
    assign OFFSET_REFERENCE_SELECT_O = s_r.ofs_ref_cfg[`ACCR_OFS_REF_SEL_BIT];
    assign OFFSET_AVERAGE_DEPTH_O = s_r.avg_cfg[`ACCR_OFS_AVG_MSB:`ACCR_OFS_AVG_LSB];
    assign LINEARITY_AVERAGE_DEPTH_O = s_r.avg_cfg[`ACCR_LIN_AVG_MSB:`ACCR_LIN_AVG_LSB];
    assign BACKGROUND_ENABLE_O = s_r.control[`ACCR_CTRL_BG_BIT];
    assign CAL_RUN_O = s_r.control[`ACCR_CTRL_RUN_BIT];
    assign CAL_TRIGGER_O = s_r.cal_trigger;
    assign OFFSET_ERROR_O = s_r.ofs_err;

endmodule

`default_nettype wire

// file: verification/accr_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module accr_top_asserts (
    input wire logic        REF_CLK_I,                 // Clock
    input wire logic        RST_N_I,                   // Reset
    input wire logic [7:0]  ADDR_I,                    // Address
    input wire logic [7:0]  WR_DATA_I,                 // Write data
    input wire logic        WR_STB_I,                  // Write strobe
    input wire logic        RD_STB_I,                  // Read strobe
    input wire logic [7:0]  RD_DATA_O,                 // Read data
    input wire logic        TRIGGER_INPUT_PIN_I,       // Trigger pin
    input wire logic [11:0] CORE_SAMPLE_I,             // Core sample
    input wire logic [11:0] SPARE_SAMPLE_I,            // Spare sample
    input wire logic        STATUS_OUTPUT_PIN_O,       // Status pin
    input wire logic        IRQ_O,                     // Interrupt
    input wire logic        OFFSET_REFERENCE_SELECT_O, // Reference choice
    input wire logic [2:0]  OFFSET_AVERAGE_DEPTH_O,    // Offset depth
    input wire logic [2:0]  LINEARITY_AVERAGE_DEPTH_O, // Linearity depth
    input wire logic        CAL_TRIGGER_O,             // Trigger
    input wire logic [12:0] OFFSET_ERROR_O             // Offset error
);
    // Shadows of written fields, so no internal probes are needed
    logic       src_r;
    logic       soft_r;
    logic [1:0] sel_r;
    logic [2:0] mask_r;
    logic [2:0] up_r;
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            src_r  <= 1'b0;
            soft_r <= 1'b1;
            sel_r  <= 2'h0;
            mask_r <= 3'h0;
            up_r   <= 3'h0;
        end else begin
            up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
            if (WR_STB_I && ADDR_I == 8'h6b) begin
                src_r <= WR_DATA_I[0];
                sel_r <= WR_DATA_I[2:1];
            end
            if (WR_STB_I && ADDR_I == 8'h6c) begin
                soft_r <= WR_DATA_I[0];
            end
            if (WR_STB_I && ADDR_I == 8'h91) begin
                mask_r <= WR_DATA_I[2:0];
            end
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Four samples so a one-cycle lag of the select output cannot mislead
    sequence s_ref_mid;
        !OFFSET_REFERENCE_SELECT_O [*4];
    endsequence
    sequence s_ref_spare;
        OFFSET_REFERENCE_SELECT_O [*4];
    endsequence
    property p_avg;
        logic [7:0] d;
        (WR_STB_I && ADDR_I == 8'h68, d = WR_DATA_I) |-> ##2
            (OFFSET_AVERAGE_DEPTH_O == d[6:4] && LINEARITY_AVERAGE_DEPTH_O == d[2:0]);
    endproperty
    a_ref_midcode: assert property (s_ref_mid |->
        $past(OFFSET_ERROR_O) == {1'b0, $past(CORE_SAMPLE_I, 2)} - 13'h0800)
        else $error("offset error not against mid-code");
    a_ref_spare: assert property (s_ref_spare |->
        $past(OFFSET_ERROR_O) == {1'b0, $past(CORE_SAMPLE_I, 2)} - {1'b0, $past(SPARE_SAMPLE_I, 2)})
        else $error("offset error not against spare sample");
    a_avg_depth: assert property (p_avg)
        else $error("averaging depth outputs wrong");
    a_state_upper: assert property (RD_STB_I && ADDR_I == 8'h6a |=> RD_DATA_O[7:5] == 3'h0)
        else $error("state upper bits not zero");
    a_stat_low: assert property (sel_r == 2'h3 && $past(sel_r) == 2'h3 && up_r >= 3'h2
        |-> !STATUS_OUTPUT_PIN_O) else $error("status pin not low for code three");
    a_trig_soft: assert property (!src_r && $stable(src_r) && $stable(soft_r) && up_r >= 3'h2
        |-> CAL_TRIGGER_O == soft_r) else $error("trigger not from software bit");
    a_trig_pin: assert property (src_r && $past(src_r, 4) && up_r >= 3'h5
        |-> CAL_TRIGGER_O == $past(TRIGGER_INPUT_PIN_I, 3)) else $error("trigger not from pin");
    a_irq_masked: assert property (mask_r == 3'h0 && $stable(mask_r) |-> !IRQ_O)
        else $error("interrupt with all events masked");
endmodule
bind accr_top accr_top_asserts accr_top_asserts_inst (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
    .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .RD_DATA_O(RD_DATA_O),
    .TRIGGER_INPUT_PIN_I(TRIGGER_INPUT_PIN_I), .CORE_SAMPLE_I(CORE_SAMPLE_I),
    .SPARE_SAMPLE_I(SPARE_SAMPLE_I), .STATUS_OUTPUT_PIN_O(STATUS_OUTPUT_PIN_O), .IRQ_O(IRQ_O),
    .OFFSET_REFERENCE_SELECT_O(OFFSET_REFERENCE_SELECT_O),
    .OFFSET_AVERAGE_DEPTH_O(OFFSET_AVERAGE_DEPTH_O),
    .LINEARITY_AVERAGE_DEPTH_O(LINEARITY_AVERAGE_DEPTH_O),
    .CAL_TRIGGER_O(CAL_TRIGGER_O), .OFFSET_ERROR_O(OFFSET_ERROR_O)
);
`default_nettype wire

// file: verification/tb_accr_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_accr_top;
    logic        REF_CLK_I;
    logic        RST_N_I;
    logic [7:0]  ADDR_I;
    logic [7:0]  WR_DATA_I;
    logic        WR_STB_I;
    logic        RD_STB_I;
    logic [7:0]  RD_DATA_O;
    logic        TRIGGER_INPUT_PIN_I;
    logic        ALARM_I;
    logic [11:0] CORE_SAMPLE_I;
    logic [11:0] SPARE_SAMPLE_I;
    logic        STATUS_OUTPUT_PIN_O;
    logic        IRQ_O;
    logic        OFFSET_REFERENCE_SELECT_O;
    logic [2:0]  OFFSET_AVERAGE_DEPTH_O;
    logic [2:0]  LINEARITY_AVERAGE_DEPTH_O;
    logic        BACKGROUND_ENABLE_O;
    logic        CAL_RUN_O;
    logic        CAL_TRIGGER_O;
    logic [12:0] OFFSET_ERROR_O;
    int          n_errors;
    int          checked;

    accr_top accr_top_inst (
        .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I),
        .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .RD_DATA_O(RD_DATA_O),
        .TRIGGER_INPUT_PIN_I(TRIGGER_INPUT_PIN_I), .ALARM_I(ALARM_I),
        .CORE_SAMPLE_I(CORE_SAMPLE_I), .SPARE_SAMPLE_I(SPARE_SAMPLE_I),
        .STATUS_OUTPUT_PIN_O(STATUS_OUTPUT_PIN_O), .IRQ_O(IRQ_O),
        .OFFSET_REFERENCE_SELECT_O(OFFSET_REFERENCE_SELECT_O),
        .OFFSET_AVERAGE_DEPTH_O(OFFSET_AVERAGE_DEPTH_O),
        .LINEARITY_AVERAGE_DEPTH_O(LINEARITY_AVERAGE_DEPTH_O),
        .BACKGROUND_ENABLE_O(BACKGROUND_ENABLE_O), .CAL_RUN_O(CAL_RUN_O),
        .CAL_TRIGGER_O(CAL_TRIGGER_O), .OFFSET_ERROR_O(OFFSET_ERROR_O)
    );

    task automatic stop_test();
        $display("mismatches %0d of %0d checks", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge REF_CLK_I);
        WR_STB_I  <= 1'b1;
        ADDR_I    <= a;
        WR_DATA_I <= v;
        @(posedge REF_CLK_I);
        WR_STB_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge REF_CLK_I);
        RD_STB_I <= 1'b1;
        ADDR_I   <= a;
        @(posedge REF_CLK_I);
        RD_STB_I <= 1'b0;
        #1;
        v = RD_DATA_O;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(16'(v), 16'(exp));
    endtask
    // Bounded poll of the state register; engine timing is the designer's choice
    task automatic poll(input logic [7:0] exp);
        logic [7:0] v;
        for (int i = 0; i < 300; i++) begin
            rd(8'h6a, v);
            if (v === exp) break;
        end
        chk(16'(v), 16'(exp));
    endtask
    task automatic t_regs();
        rdc(8'h65, 8'h01);
        rdc(8'h68, 8'h61);
        rdc(8'h6b, 8'h00);
        rdc(8'h6c, 8'h01);
        rdc(8'h92, 8'h05);
        rdc(8'h91, 8'h00);
        rdc(8'h70, 8'h00);
        wr(8'h6a, 8'hff);
        chk(16'({OFFSET_AVERAGE_DEPTH_O, LINEARITY_AVERAGE_DEPTH_O,
            BACKGROUND_ENABLE_O}), 16'h0062);
    endtask
    task automatic t_pin();
        @(posedge REF_CLK_I);
        ALARM_I <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(8'(s << 1), 8'h00);
            wr(8'h6b, 8'(s << 1));
            cyc(3);
            chk(16'(STATUS_OUTPUT_PIN_O), 16'(s != 3));
        end
        @(posedge REF_CLK_I);
        ALARM_I <= 1'b0;
        wr(8'h6b, 8'h04);
        cyc(4);
        chk(16'(STATUS_OUTPUT_PIN_O), 16'h0000);
    endtask
    task automatic t_irq();
        chk(16'(IRQ_O), 16'h0000);
        rdc(8'h90, 8'h07);
        wr(8'h91, 8'h04);
        cyc(2);
        chk(16'(IRQ_O), 16'h0001);
        wr(8'h90, 8'h04);
        cyc(2);
        chk(16'(IRQ_O), 16'h0000);
        rdc(8'h90, 8'h03);
        wr(8'h91, 8'h02);
        wr(8'h90, 8'h03);
    endtask
    task automatic t_ref();
        @(posedge REF_CLK_I);
        CORE_SAMPLE_I <= 12'h900;
        cyc(3);
        chk(16'(OFFSET_ERROR_O), 16'h0100);
        wr(8'h92, 8'h00);
        wr(8'h68, 8'h01);
        wr(8'h6b, 8'h00);
        wr(8'h92, 8'h06);
        wr(8'h65, 8'h05);
        wr(8'h92, 8'h07);
        CORE_SAMPLE_I  <= 12'h100;
        SPARE_SAMPLE_I <= 12'h300;
        cyc(3);
        chk(16'(OFFSET_ERROR_O), 16'h1e00);
        chk(16'({OFFSET_REFERENCE_SELECT_O, BACKGROUND_ENABLE_O, CAL_RUN_O,
            OFFSET_AVERAGE_DEPTH_O, LINEARITY_AVERAGE_DEPTH_O}), 16'h01c1);
    endtask
    task automatic t_bg();
        poll(8'h0d);
        // Running background: done is high, halted low, so codes 0 and 1 differ here
        wr(8'h6b, 8'h02);
        cyc(3);
        chk(16'(STATUS_OUTPUT_PIN_O), 16'h0000);
        wr(8'h6c, 8'h00);
        cyc(3);
        chk(16'(CAL_TRIGGER_O), 16'h0000);
        poll(8'h13);
        chk(16'(IRQ_O), 16'h0001);
        chk(16'(STATUS_OUTPUT_PIN_O), 16'h0001);
        wr(8'h6c, 8'h01);
        poll(8'h0d);
        wr(8'h6b, 8'h01);
        poll(8'h13);
        @(posedge REF_CLK_I);
        TRIGGER_INPUT_PIN_I <= 1'b1;
        cyc(4);
        chk(16'(CAL_TRIGGER_O), 16'h0001);
        poll(8'h0d);
        wr(8'h6c, 8'h00);
        cyc(40);
        rdc(8'h6a, 8'h0d);
        wr(8'h6b, 8'h00);
        cyc(3);
        chk(16'(CAL_TRIGGER_O), 16'h0000);
    endtask
    // Foreground skipped with background off: both flags set without a phase
    task automatic t_skip();
        wr(8'h92, 8'h00);
        wr(8'h65, 8'h01);
        wr(8'h92, 8'h01);
        cyc(3);
        rdc(8'h6a, 8'h0b);
        chk(16'({OFFSET_REFERENCE_SELECT_O, BACKGROUND_ENABLE_O, CAL_RUN_O}), 16'h0001);
    endtask

    initial begin
        REF_CLK_I = 1'b0;
        forever #10 REF_CLK_I = ~REF_CLK_I;
    end
    initial begin
        RST_N_I = 1'b0;
        ADDR_I = 8'h00;
        WR_DATA_I = 8'h00;
        WR_STB_I = 1'b0;
        RD_STB_I = 1'b0;
        TRIGGER_INPUT_PIN_I = 1'b0;
        ALARM_I = 1'b0;
        CORE_SAMPLE_I = 12'h800;
        SPARE_SAMPLE_I = 12'h800;
        n_errors = 0;
        checked = 0;
        repeat (8) @(posedge REF_CLK_I);
        RST_N_I <= 1'b1;
        t_regs();
        poll(8'h0b);
        t_pin();
        t_irq();
        t_ref();
        t_bg();
        t_skip();
        stop_test();
    end
    // Whole sequence needs a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge REF_CLK_I);
        n_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
